// >>> src/startup_pkg.sv
// Constants, field layout and types for the configuration startup sequencer
package startup_pkg;

  // ==========================================================================
  // Bus
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CONFIG_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
  localparam logic [ADDR_W-1:0] READBACK_OFFSET = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================================
  // Config register layout
  localparam int PHASE_W = 3;
  localparam int CODE_W = 4;
  localparam int DONE_PHASE_LSB = 0;
  localparam int DONE_PIPE_BIT = 3;
  localparam int TRISTATE_LSB = 4;
  localparam int WRITE_EN_LSB = 8;
  localparam int LOCK_LSB = 12;
  localparam int MATCH_LSB = 16;
  localparam int CALIB_IO_BIT = 20;
  localparam int ACTIVE_RECONFIG_BIT = 21;
  localparam int SECURITY_LSB = 22;
  localparam int PORT_SEL_LSB = 24;
  localparam int START_BIT = 0;

  // ==========================================================================
  // Phase and wait codes
  localparam logic [CODE_W-1:0] PHASE_FIRST = 4'h1;
  localparam logic [CODE_W-1:0] PHASE_LAST = 4'h6;
  localparam logic [CODE_W-1:0] PHASE_AT_DONE = 4'hE;
  localparam logic [CODE_W-1:0] PHASE_KEEP = 4'hF;
  localparam logic [CODE_W-1:0] WAIT_AUTO = 4'hE;
  localparam logic [CODE_W-1:0] WAIT_NONE = 4'hF;
  localparam logic [CODE_W-1:0] AUTO_MATCH_PHASE = 4'h2;
  localparam logic [PHASE_W-1:0] PHASE_MAX = 3'h6;
  localparam logic [1:0] SECURITY_NONE = 2'h0;
  localparam logic [1:0] SECURITY_LEVEL2 = 2'h2;
  localparam logic [1:0] PORT_BOTTOM = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic [PHASE_W-1:0] DONE_PHASE_RESET = 3'h4;
  localparam logic [CODE_W-1:0] TRISTATE_RESET = 4'h5;
  localparam logic [CODE_W-1:0] WRITE_EN_RESET = 4'h6;
  localparam logic [CODE_W-1:0] LOCK_RESET = WAIT_NONE;
  localparam logic [CODE_W-1:0] MATCH_RESET = WAIT_AUTO;
  localparam logic [31:0] CONFIG_RESET = {12'h000, MATCH_RESET, LOCK_RESET,
    WRITE_EN_RESET, TRISTATE_RESET, 1'b0, DONE_PHASE_RESET};
  localparam logic [31:0] CONFIG_MASK = 32'h03FF_FFFF;

  // ==========================================================================
  // Status register layout
  localparam int STATUS_PHASE_LSB = 0;
  localparam int STATUS_DONE_BIT = 3;
  localparam int STATUS_RELEASED_BIT = 4;
  localparam int STATUS_WRITE_EN_BIT = 5;
  localparam int STATUS_LOCK_BIT = 6;
  localparam int STATUS_MATCH_BIT = 7;
  localparam int STATUS_STATE_LSB = 8;
  localparam int STATUS_STALL_BIT = 10;
  localparam int STATUS_BOTTOM_BIT = 11;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN = 2'b01,
    SEQ_FINISH = 2'b11
  } seq_state_e;

endpackage

// >>> src/level_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> src/phase_reach.sv
// Decides whether a phase-selected global signal has been reached
`timescale 1ns/1ps
`default_nettype none
module phase_reach (
  input wire logic [startup_pkg::CODE_W-1:0] code,
  input wire logic [startup_pkg::PHASE_W-1:0] phase,
  input wire logic running,
  input wire logic done,
  output logic reached
);
  import startup_pkg::*;

  // Unlisted codes behave as keep
  always_comb begin
    reached = 1'b0;
    if (code == PHASE_AT_DONE) begin
      reached = done;
    end else if (code >= PHASE_FIRST && code <= PHASE_LAST) begin
      reached = running && ({1'b0, phase} >= code);
    end
  end
endmodule
`default_nettype wire

// >>> src/config_startup_sequencer.sv
// Startup sequencer with AXI4-Lite configuration, status and readback
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module config_startup_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [startup_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [startup_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic clock_manager_locked,
  input wire logic impedance_calibration_matched,
  output logic done,
  output logic global_tristate,
  output logic global_write_enable,
  output logic block_memory_enable,
  output logic global_hold,
  output logic global_set_reset,
  output logic internal_port_bottom
);
  import startup_pkg::*;

  // ==========================================================================
  // Declarations
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [31:0] w_data_q, w_data_d, cfg_w;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, cfg_q, cfg_d;
  logic start_req;
  seq_state_e seq_q, seq_d;
  logic [PHASE_W-1:0] phase_q, phase_d;
  logic done_q, done_d, done_stage_q, done_stage_d, done_reached, stall;
  logic tristate_q, tristate_d, write_en_q, write_en_d;
  logic hold_q, hold_d, port_bottom_q, port_bottom_d;
  logic lock_sync, match_sync;
  logic [1:0] sync_vec;
  logic [1:0] reached;
  logic [CODE_W-1:0] sel_code [2];
  logic [PHASE_W-1:0] done_sel;
  logic [CODE_W-1:0] lock_code, match_raw, match_code;
  logic done_pipe, active_reconfig;
  logic [1:0] security, port_sel;

  assign done_sel = cfg_q[DONE_PHASE_LSB +: PHASE_W];
  assign done_pipe = cfg_q[DONE_PIPE_BIT];
  assign sel_code[0] = cfg_q[TRISTATE_LSB +: CODE_W];
  assign sel_code[1] = cfg_q[WRITE_EN_LSB +: CODE_W];
  assign lock_code = cfg_q[LOCK_LSB +: CODE_W];
  assign match_raw = cfg_q[MATCH_LSB +: CODE_W];
  assign active_reconfig = cfg_q[ACTIVE_RECONFIG_BIT];
  assign security = cfg_q[SECURITY_LSB +: 2];
  assign port_sel = cfg_q[PORT_SEL_LSB +: 2];
  // Auto resolves from the calibrated-I/O flag
  assign match_code = (match_raw != WAIT_AUTO) ? match_raw :
    (cfg_q[CALIB_IO_BIT] ? AUTO_MATCH_PHASE : WAIT_NONE);

  // ==========================================================================
  // Pin synchronisers
  level_sync #(.WIDTH(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({impedance_calibration_matched, clock_manager_locked}),
    .sync_out(sync_vec)
  );
  assign lock_sync = sync_vec[0];
  assign match_sync = sync_vec[1];

  // ==========================================================================
  // Phase decoders: 0 tristate release, 1 write enable
  for (genvar g = 0; g < 2; g++) begin : g_reach
    phase_reach u_reach (
      .code(sel_code[g]),
      .phase(phase_q),
      .running(seq_q != SEQ_IDLE),
      .done(done_q),
      .reached(reached[g])
    );
  end

  // ==========================================================================
  // AXI4-Lite slave
  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d = w_hold_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    cfg_d = cfg_q;
    cfg_w = cfg_q;
    start_req = 1'b0;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (aw_hold_q && w_hold_q && !bvalid_q) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      for (int i = 0; i < 4; i++) begin
        if (w_strb_q[i]) begin
          cfg_w[8*i +: 8] = w_data_q[8*i +: 8];
        end
      end
      case (aw_addr_q)
        CONFIG_OFFSET: begin
          // Settings frozen once startup is under way
          if (security == SECURITY_LEVEL2) begin
            bresp_d = RESP_SLVERR;
          end else if (seq_q == SEQ_IDLE) begin
            cfg_d = cfg_w & CONFIG_MASK;
          end
        end
        CONTROL_OFFSET: start_req = w_strb_q[0] && w_data_q[START_BIT];
        STATUS_OFFSET, READBACK_OFFSET: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_DECERR;
      endcase
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      case (s_axi_araddr)
        CONFIG_OFFSET: rdata_d = cfg_q;
        CONTROL_OFFSET: rdata_d = '0;
        STATUS_OFFSET: begin
          rdata_d[STATUS_PHASE_LSB +: PHASE_W] = phase_q;
          rdata_d[STATUS_DONE_BIT] = done_q;
          rdata_d[STATUS_RELEASED_BIT] = !tristate_q;
          rdata_d[STATUS_WRITE_EN_BIT] = write_en_q;
          rdata_d[STATUS_LOCK_BIT] = lock_sync;
          rdata_d[STATUS_MATCH_BIT] = match_sync;
          rdata_d[STATUS_STATE_LSB +: 2] = seq_q;
          rdata_d[STATUS_STALL_BIT] = stall;
          rdata_d[STATUS_BOTTOM_BIT] = port_bottom_q;
        end
        READBACK_OFFSET: begin
          if (security == SECURITY_NONE) begin
            rdata_d = cfg_q;
          end else begin
            rresp_d = RESP_SLVERR;
          end
        end
        default: rresp_d = RESP_DECERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      cfg_q <= CONFIG_RESET;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q <= w_hold_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      cfg_q <= cfg_d;
    end
  end

  // ==========================================================================
  // Startup sequencer
  always_comb begin
    seq_d = seq_q;
    phase_d = phase_q;
    stall = 1'b0;
    if (seq_q == SEQ_RUN) begin
      stall = (lock_code == {1'b0, phase_q} && !lock_sync) ||
        (match_code == {1'b0, phase_q} && !match_sync);
    end
    case (seq_q)
      SEQ_IDLE: begin
        if (start_req) begin
          seq_d = SEQ_RUN;
          phase_d = '0;
        end
      end
      SEQ_RUN: begin
        if (!stall) begin
          phase_d = phase_q + 3'h1;
          if (phase_q == PHASE_MAX) begin
            seq_d = SEQ_FINISH;
          end
        end
      end
      SEQ_FINISH: seq_d = SEQ_FINISH;
      default: seq_d = SEQ_IDLE;
    endcase
    done_reached = (seq_q != SEQ_IDLE) && (phase_q >= done_sel);
    done_stage_d = done_reached;
    done_d = done_pipe ? done_stage_q : done_reached;
    tristate_d = !reached[0];
    write_en_d = reached[1];
    // Hold and set/reset stay up only before the start command, and never while active reconfig is set
    hold_d = (seq_q == SEQ_IDLE) && !active_reconfig;
    port_bottom_d = (port_sel == PORT_BOTTOM);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q <= SEQ_IDLE;
      phase_q <= '0;
      done_q <= 1'b0;
      done_stage_q <= 1'b0;
      tristate_q <= 1'b1;
      write_en_q <= 1'b0;
      hold_q <= 1'b1;
      port_bottom_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      phase_q <= phase_d;
      done_q <= done_d;
      done_stage_q <= done_stage_d;
      tristate_q <= tristate_d;
      write_en_q <= write_en_d;
      hold_q <= hold_d;
      port_bottom_q <= port_bottom_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign done = done_q;
  assign global_tristate = tristate_q;
  assign global_write_enable = write_en_q;
  // Memories share the write-enable flop so they cannot lead it
  assign block_memory_enable = write_en_q;
  assign global_hold = hold_q;
  assign global_set_reset = hold_q;
  assign internal_port_bottom = port_bottom_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence done_late_s;
    !done_q ##1 done_q;
  endsequence

  done_phase_a: assert property ((seq_q != SEQ_IDLE && !done_pipe &&
    phase_q >= done_sel) |=> done_q)
    else $error("done missing in its phase");
  done_pipe_a: assert property ((done_pipe && $rose(done_reached))
    |=> done_late_s)
    else $error("pipelined done not one cycle late");
  tristate_phase_a: assert property ((seq_q != SEQ_IDLE &&
    sel_code[0] >= PHASE_FIRST && sel_code[0] <= PHASE_LAST &&
    {1'b0, phase_q} >= sel_code[0]) |=> !global_tristate)
    else $error("tristate not released in phase");
  tristate_keep_a: assert property ((sel_code[0] == PHASE_KEEP)
    |=> global_tristate)
    else $error("tristate released under keep");
  write_done_a: assert property ((sel_code[1] == PHASE_AT_DONE)
    |=> global_write_enable == $past(done_q))
    else $error("write enable not tied to done");
  bram_gated_a: assert property ((seq_q == SEQ_IDLE)
    |=> !block_memory_enable && !global_write_enable)
    else $error("block memory enabled before startup");
  lock_stall_a: assert property ((seq_q == SEQ_RUN && !lock_sync &&
    lock_code == {1'b0, phase_q}) |=> phase_q == $past(phase_q))
    else $error("phase moved without lock");
  match_stall_a: assert property ((seq_q == SEQ_RUN &&
    !match_sync && match_code == {1'b0, phase_q})
    |=> phase_q == $past(phase_q))
    else $error("phase moved without match");
  hold_reconfig_a: assert property (active_reconfig
    |=> !global_hold && !global_set_reset)
    else $error("hold asserted under active reconfig");
  readback_refused_a: assert property ((s_axi_arvalid &&
    arready_q && s_axi_araddr == READBACK_OFFSET &&
    security != SECURITY_NONE)
    |=> rvalid_q && rresp_q == RESP_SLVERR && rdata_q == 32'h0000_0000)
    else $error("secured readback not refused");
  port_route_a: assert property (1'b1 |=>
    internal_port_bottom == $past(port_sel == PORT_BOTTOM))
    else $error("internal port route wrong");
  phase_step_a: assert property ((seq_q == SEQ_RUN && !stall)
    |=> phase_q == $past(phase_q) + 3'h1)
    else $error("phase did not step by one");
endmodule
`default_nettype wire

// >>> test/startup_partner.sv
// Model of the clock managers, calibration and configuration controller
`timescale 1ns/1ps
`default_nettype none
module startup_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic done,
  input wire logic calib_io_used,
  input wire logic [7:0] lock_at,
  input wire logic [7:0] match_at,
  output logic locked,
  output logic matched,
  output logic keep_clocking,
  output logic [startup_pkg::CODE_W-1:0] match_choice
);
  import startup_pkg::*;
  logic [7:0] age_q;
  logic [7:0] age_d;

  // ==========================================================================
  // Age since configuration start
  // Saturates, so a level set at 8'hFF rises only after 255 cycles
  always_comb begin
    age_d = (age_q == 8'hFF) ? age_q : age_q + 8'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age_q <= 8'h00;
    end else begin
      age_q <= age_d;
    end
  end

  // ==========================================================================
  // Levels seen by the device
  // Plain levels; the device does its own synchronising
  assign locked = (age_q >= lock_at);
  assign matched = (age_q >= match_at);
  assign keep_clocking = !done;
  assign match_choice = calib_io_used ? AUTO_MATCH_PHASE :
    WAIT_NONE;
endmodule
`default_nettype wire

// >>> test/config_startup_sequencer_tb_top.sv
// Self-checking bench for the configuration startup sequencer
`timescale 1ns/1ps
`default_nettype none
module config_startup_sequencer_tb_top;
  import startup_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, calib_use = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, cfg;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, clock_manager_locked, impedance_calibration_matched;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic done, global_tristate, global_write_enable, block_memory_enable;
  logic global_hold, global_set_reset, internal_port_bottom, keep_clocking;
  logic [3:0] match_choice;
  logic [7:0] lock_at = 8'hFF, match_at = 8'hFF;
  int cyc = 0, b_cyc, t0, miscompares = 0, compares = 0;
  int m_done, m_ts, m_we, m_bme, m_hold, m_lock, m_match;

  config_startup_sequencer dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .clock_manager_locked, .impedance_calibration_matched, .done,
    .global_tristate, .global_write_enable, .block_memory_enable,
    .global_hold, .global_set_reset, .internal_port_bottom);

  startup_partner partner (.aclk, .aresetn, .done,
    .calib_io_used(calib_use), .lock_at, .match_at,
    .locked(clock_manager_locked), .matched(impedance_calibration_matched),
    .keep_clocking, .match_choice);

  // ==========================================================================
  // Clock and edge marks
  initial begin
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) cyc <= cyc + 1;

  // Sampled mid-cycle so every mark is the count of the edge that set it
  always @(negedge aclk) begin
    if (done && m_done < 0) m_done = cyc;
    if (!global_tristate && m_ts < 0) m_ts = cyc;
    if (global_write_enable && m_we < 0) m_we = cyc;
    if (block_memory_enable && m_bme < 0) m_bme = cyc;
    if (!global_hold && m_hold < 0) m_hold = cyc;
    if (clock_manager_locked && m_lock < 0) m_lock = cyc;
    if (impedance_calibration_matched && m_match < 0) m_match = cyc;
  end

  // ==========================================================================
  // Tasks
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    {m_done, m_ts, m_we, m_bme} = {4{-32'sd1}};
    {m_hold, m_lock, m_match} = {3{-32'sd1}};
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] dat,
      input logic [3:0] s, output logic [1:0] resp);
    logic ah, wh, ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= dat;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      ad = ad || ah;
      wd = wd || wh;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    do begin
      @(negedge aclk);
      resp = s_axi_bresp;
      b_cyc = cyc;
      ah = s_axi_bvalid;
      @(posedge aclk);
    end while (!ah);
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] dat,
      output logic [1:0] resp);
    logic h;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      h = s_axi_arready;
      @(posedge aclk);
    end while (!h);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge aclk);
      h = s_axi_rvalid;
      dat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
    end while (!h);
    s_axi_rready <= 1'h0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] ed,
      input logic [1:0] er);
    axi_read(a, d, r);
    check_val(d, ed);
    check_val({30'h0, r}, {30'h0, er});
  endtask

  function automatic int rel(input int m);
    return (m < 0) ? -1 : m - t0;
  endfunction

  function automatic int exp_at(input logic [3:0] c, input int dr);
    if (c >= PHASE_FIRST && c <= PHASE_LAST) return int'(c) + 1;
    return (c == PHASE_AT_DONE) ? dr + 1 : -1;
  endfunction

  task automatic start_run(input logic [31:0] c);
    do_reset;
    axi_write(CONFIG_OFFSET, c, 4'hF, r);
    axi_write(CONTROL_OFFSET, 32'h1, 4'h1, r);
    t0 = b_cyc;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (keep_clocking && n < 80) begin
      @(posedge aclk);
      n++;
    end
    repeat (4) @(posedge aclk);
  endtask

  task automatic run_check(input logic [31:0] c);
    int dr;
    start_run(c);
    wait_done;
    dr = int'(c[2:0]) + 1 + int'(c[3]);
    check_val(rel(m_done), dr);
    check_val(rel(m_ts), exp_at(c[7:4], dr));
    check_val(rel(m_we), exp_at(c[11:8], dr));
    check_val(rel(m_bme), exp_at(c[11:8], dr));
    check_val({31'h0, rel(m_hold) == 1}, {31'h0, !c[21]});
    check_val({30'h0, global_hold, global_set_reset}, 32'h0);
  endtask

  // ==========================================================================
  // Tests
  initial begin
    do_reset;
    check_val({25'h0, done, global_tristate, global_write_enable,
      block_memory_enable, global_hold, global_set_reset,
      internal_port_bottom}, 32'h26);
    rd_chk(CONFIG_OFFSET, CONFIG_RESET, RESP_OKAY);
    rd_chk(4'h2, 32'h0, RESP_DECERR);
    axi_write(4'h6, 32'h1, 4'hF, r);
    check_val({30'h0, r}, {30'h0, RESP_DECERR});
    axi_write(CONFIG_OFFSET, 32'hFFFF_FFFF, 4'h2, r);
    rd_chk(CONFIG_OFFSET, 32'h000E_FF54, RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      cfg = CONFIG_RESET | (32'(p) << PORT_SEL_LSB);
      axi_write(CONFIG_OFFSET, cfg, 4'hF, r);
      rd_chk(READBACK_OFFSET, cfg, RESP_OKAY);
      check_val({31'h0, internal_port_bottom}, {31'h0, p == 2});
    end
    cfg = CONFIG_RESET | (32'h1 << SECURITY_LSB);
    axi_write(CONFIG_OFFSET, cfg, 4'hF, r);
    rd_chk(READBACK_OFFSET, 32'h0, RESP_SLVERR);
    // Level two also freezes the settings word
    cfg = CONFIG_RESET | (32'h2 << SECURITY_LSB);
    axi_write(CONFIG_OFFSET, cfg, 4'hF, r);
    axi_write(CONFIG_OFFSET, CONFIG_RESET, 4'hF, r);
    check_val({30'h0, r}, {30'h0, RESP_SLVERR});
    rd_chk(READBACK_OFFSET, 32'h0, RESP_SLVERR);
    rd_chk(CONFIG_OFFSET, cfg, RESP_OKAY);
    // Waits are left off with both inputs low, so nothing may stall
    run_check(CONFIG_RESET);
    for (int i = 1; i <= 6; i++) begin
      cfg = CONFIG_RESET;
      cfg[2:0] = 3'(i);
      cfg[3] = i[0];
      cfg[7:4] = 4'(i);
      cfg[11:8] = 4'(7 - i);
      run_check(cfg);
    end
    cfg[7:4] = PHASE_AT_DONE;
    cfg[11:8] = PHASE_KEEP;
    run_check(cfg);
    cfg[7:4] = PHASE_KEEP;
    cfg[11:8] = PHASE_AT_DONE;
    run_check(cfg);
    run_check(CONFIG_RESET | (32'h1 << ACTIVE_RECONFIG_BIT));
    // Lock wait in phase 3; lock arrives 40 cycles after start of config
    cfg = CONFIG_RESET;
    cfg[15:12] = 4'h3;
    lock_at <= 8'h28;
    match_at <= 8'h00;
    calib_use <= 1'h1;
    start_run(cfg);
    repeat (6) @(posedge aclk);
    rd_chk(STATUS_OFFSET, 32'h583, RESP_OKAY);
    axi_write(CONFIG_OFFSET, 32'h0, 4'hF, r);
    rd_chk(CONFIG_OFFSET, cfg, RESP_OKAY);
    wait_done;
    check_val(m_done - m_lock, 32'h4);
    // Match wait in phase 2, by auto choice and by the controller's pick
    lock_at <= 8'h00;
    match_at <= 8'h28;
    for (int k = 0; k < 2; k++) begin
      cfg = CONFIG_RESET;
      if (k == 0) cfg[CALIB_IO_BIT] = 1'h1;
      else cfg[19:16] = match_choice;
      start_run(cfg);
      repeat (6) @(posedge aclk);
      rd_chk(STATUS_OFFSET, 32'h542, RESP_OKAY);
      wait_done;
      check_val(m_done - m_match, 32'h5);
    end
    tally_and_finish;
  end

  // Whole plan is about 600 cycles; 6000 means a hang
  initial begin
    #600000;
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
